//--- core/asop_pkg.sv
/*
 Constants for the sample output port of the 8-bit sampling converter.
 Assumes one 100 MHz system clock; the conversion clock arrives as a synchronous input.
*/
package asop_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned PIPE_DEPTH = 3;
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned MAX_MSPS = 42;
   // Fewest system clocks in one conversion period at the top sample rate
   localparam int unsigned MIN_CONV_CYC = (CLK_MHZ + MAX_MSPS - 1) / MAX_MSPS;
   localparam logic [DATA_W-1:0] WORD_RESET = 8'h00;
   localparam logic [7:0] GAP_MAX = 8'hFF;
   localparam logic [7:0] GAP_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] OE_ALL = 8'hFF;
   localparam logic [DATA_W-1:0] OE_NONE = 8'h00;
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   typedef enum logic [0:0] {ASOP_RUN, ASOP_SLEEP} asop_mode_type;
endpackage

//--- core/asop_edge.sv
/*
 Edge finder for the conversion clock input.
 Assumes conv_clk_i is synchronous to clk_i and slower than half its rate.
*/
module asop_edge (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic conv_clk_i,
   output logic [1:0] edge_o
);
   logic prev_q;
   logic prev_d;

   always_comb begin
      prev_d = conv_clk_i;
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
      end
   end

   always_comb begin
      if (conv_clk_i && !prev_q) begin
         edge_o = asop_pkg::EDGE_RISE;
      end else if (!conv_clk_i && prev_q) begin
         edge_o = asop_pkg::EDGE_FALL;
      end else begin
         edge_o = asop_pkg::EDGE_NONE;
      end
   end
endmodule

//--- core/asop_top.sv
/*
 Digital side of an 8-bit sampling converter: samples the quantised input on each
 falling conversion clock edge while awake, pipelines it and presents it after a rising edge.
 Assumes the quantiser supplies an 8-bit straight-binary code on analog_code_i and
 that the surrounding pad logic resolves the bus from data and enable outputs.
*/
// How it works
// - A fresh sample is taken on every falling edge of conversion clock outside sleep.
// - Results are 8-bit unsigned straight binary, zero scale all zeros.
// - Bus updates just after each rising edge outside sleep; host captures later.
// - Output enable low drives all eight bus lines with current word.
// - Output enable high releases all eight bus lines to high impedance.
// - Sleep request high enters low-power mode; pipeline stops toggling.
// - Sleep request low runs normal conversion every clock cycle.
// - One conversion per cycle up to 42 MSPS; host must not exceed.
module asop_top (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic conv_clk_i,
   input wire logic [7:0] analog_code_i,
   input wire logic out_en_n_i,
   input wire logic sleep_request_i,
   output logic [7:0] sample_word_bits_o,
   output logic [7:0] sample_word_bits_oe_o,
   output logic sleeping_o,
   output logic rate_fault_o
);
   // ------------------------------------------------------------
   // Conversion clock edges
   // ------------------------------------------------------------
   logic [1:0] edge_w;
   logic fall_w;
   logic rise_w;

   asop_edge u_edge (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .conv_clk_i(conv_clk_i),
      .edge_o(edge_w)
   );

   // A high conversion clock at reset release reads as a rise; it reloads the reset word and restarts the gap count
   assign fall_w = (edge_w == asop_pkg::EDGE_FALL);
   assign rise_w = (edge_w == asop_pkg::EDGE_RISE);

   // ------------------------------------------------------------
   // Mode, sample pipeline and output word
   // ------------------------------------------------------------
   asop_pkg::asop_mode_type mode_q;
   asop_pkg::asop_mode_type mode_d;
   logic [7:0] pipe_q [asop_pkg::PIPE_DEPTH];
   logic [7:0] pipe_d [asop_pkg::PIPE_DEPTH];
   logic [7:0] word_q;
   logic [7:0] word_d;
   logic [7:0] gap_q;
   logic [7:0] gap_d;
   logic fault_q;
   logic fault_d;

   always_comb begin
      mode_d = sleep_request_i ? asop_pkg::ASOP_SLEEP : asop_pkg::ASOP_RUN;
      pipe_d = pipe_q;
      word_d = word_q;
      gap_d = gap_q;
      fault_d = fault_q;
      case (mode_q)
         asop_pkg::ASOP_RUN: begin
            if (fall_w) begin
               // Straight binary passes unchanged, bit i to bit i
               pipe_d[0] = analog_code_i;
               for (int i = 1; i < asop_pkg::PIPE_DEPTH; i++) begin
                  pipe_d[i] = pipe_q[i-1];
               end
            end
            if (rise_w) begin
               word_d = pipe_q[asop_pkg::PIPE_DEPTH-1];
               gap_d = asop_pkg::GAP_ZERO;
               // Flag a conversion clock faster than the rated rate
               fault_d = fault_q | (gap_q < 8'(asop_pkg::MIN_CONV_CYC - 1));
            end else if (gap_q != asop_pkg::GAP_MAX) begin
               gap_d = gap_q + 8'h01;
            end
         end
         asop_pkg::ASOP_SLEEP: begin
            // Pipeline and word registers hold to save power, gap parks at GAP_MAX; the word is stale until woken
            gap_d = asop_pkg::GAP_MAX;
         end
         default: begin
            mode_d = asop_pkg::ASOP_RUN;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_q <= asop_pkg::ASOP_RUN;
         for (int i = 0; i < asop_pkg::PIPE_DEPTH; i++) begin
            pipe_q[i] <= asop_pkg::WORD_RESET;
         end
         word_q <= asop_pkg::WORD_RESET;
         gap_q <= asop_pkg::GAP_MAX;
         fault_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         pipe_q <= pipe_d;
         word_q <= word_d;
         gap_q <= gap_d;
         fault_q <= fault_d;
      end
   end

   // ------------------------------------------------------------
   // Pins
   // ------------------------------------------------------------
   assign sample_word_bits_o = word_q;
   assign sample_word_bits_oe_o = out_en_n_i ? asop_pkg::OE_NONE : asop_pkg::OE_ALL;
   assign sleeping_o = (mode_q == asop_pkg::ASOP_SLEEP);
   assign rate_fault_o = fault_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // Pipeline checks key on the registered mode, which lags sleep_request_i by one clock
   property p_sample_fall;
      @(posedge clk_i) disable iff (!rstn_i)
         (fall_w && mode_q == asop_pkg::ASOP_RUN) |=> pipe_q[0] == $past(analog_code_i);
   endproperty
   a_sample_fall: assert property (p_sample_fall) else $error("sample missed");

   property p_hold_no_fall;
      @(posedge clk_i) disable iff (!rstn_i)
         !fall_w |=> $stable(pipe_q[0]);
   endproperty
   a_hold_no_fall: assert property (p_hold_no_fall) else $error("sample moved");

   property p_word_rise;
      @(posedge clk_i) disable iff (!rstn_i)
         (rise_w && mode_q == asop_pkg::ASOP_RUN)
            |=> sample_word_bits_o == $past(pipe_q[asop_pkg::PIPE_DEPTH-1]);
   endproperty
   a_word_rise: assert property (p_word_rise) else $error("word not updated");

   property p_word_stable;
      @(posedge clk_i) disable iff (!rstn_i)
         !rise_w |=> $stable(sample_word_bits_o);
   endproperty
   a_word_stable: assert property (p_word_stable) else $error("word moved off edge");

   property p_drive;
      @(posedge clk_i) disable iff (!rstn_i)
         !out_en_n_i |-> sample_word_bits_oe_o == asop_pkg::OE_ALL;
   endproperty
   a_drive: assert property (p_drive) else $error("bus not driven");

   property p_release;
      @(posedge clk_i) disable iff (!rstn_i)
         out_en_n_i |-> sample_word_bits_oe_o == asop_pkg::OE_NONE;
   endproperty
   a_release: assert property (p_release) else $error("bus driven while off");

   property p_sleep;
      @(posedge clk_i) disable iff (!rstn_i)
         sleep_request_i ##1 sleep_request_i |=> sleeping_o ##0 $stable(pipe_q[0]);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep ignored");

   property p_wake;
      @(posedge clk_i) disable iff (!rstn_i)
         !sleep_request_i |=> !sleeping_o;
   endproperty
   a_wake: assert property (p_wake) else $error("not running");

   property p_fault_sticky;
      @(posedge clk_i) disable iff (!rstn_i)
         rate_fault_o |=> rate_fault_o;
   endproperty
   a_fault_sticky: assert property (p_fault_sticky) else $error("fault dropped");

   property p_latency;
      @(posedge clk_i) disable iff (!rstn_i)
         (fall_w && !sleeping_o) |=> pipe_q[1] == $past(pipe_q[0]);
   endproperty
   a_latency: assert property (p_latency) else $error("pipeline skipped");

   property p_tail;
      @(posedge clk_i) disable iff (!rstn_i)
         (fall_w && !sleeping_o)
            |=> pipe_q[asop_pkg::PIPE_DEPTH-1] == $past(pipe_q[asop_pkg::PIPE_DEPTH-2]);
   endproperty
   a_tail: assert property (p_tail) else $error("pipeline tail skipped");

   property p_bit_order;
      @(posedge clk_i) disable iff (!rstn_i)
         (fall_w && !sleeping_o)
            |=> pipe_q[0][0] == $past(analog_code_i[0])
               && pipe_q[0][asop_pkg::DATA_W-1] == $past(analog_code_i[asop_pkg::DATA_W-1]);
   endproperty
   a_bit_order: assert property (p_bit_order) else $error("bit order swapped");

   property p_sleep_word;
      @(posedge clk_i) disable iff (!rstn_i)
         sleeping_o |=> $stable(sample_word_bits_o);
   endproperty
   a_sleep_word: assert property (p_sleep_word) else $error("word moved in sleep");

   property p_fast_fault;
      @(posedge clk_i) disable iff (!rstn_i)
         (rise_w && !sleeping_o && gap_q < 8'(asop_pkg::MIN_CONV_CYC - 1)) |=> rate_fault_o;
   endproperty
   a_fast_fault: assert property (p_fast_fault) else $error("fast clock not flagged");

   property p_no_false_fault;
      @(posedge clk_i) disable iff (!rstn_i)
         (!rate_fault_o && !rise_w) |=> !rate_fault_o;
   endproperty
   a_no_false_fault: assert property (p_no_false_fault) else $error("fault off a rise");

   c_sleep: cover property (@(posedge clk_i) disable iff (!rstn_i) sleeping_o ##1 !sleeping_o);
   c_word: cover property (@(posedge clk_i) disable iff (!rstn_i)
      rise_w ##1 sample_word_bits_o != 8'h00);
   c_off: cover property (@(posedge clk_i) disable iff (!rstn_i) out_en_n_i ##1 !out_en_n_i);
   c_fault: cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(rate_fault_o));
endmodule

//--- verif/asop_host_model.sv
/*
 Host model: makes the conversion clock, resolves the pad bus, captures words.
 Assumes the bench raises go_i after reset and reads cap_o while fall_o is high;
 fast_i makes an over-rate conversion clock.
*/
module asop_host_model (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic fast_i,
   input wire logic [7:0] data_i,
   input wire logic [7:0] oe_i,
   output logic conv_clk_o,
   output logic [7:0] cap_o,
   output logic fall_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] bus;
   logic [7:0] last_q = 8'h00;
   int ph = 0;
   // Released lines show the inverse of their last level, never a stale word
   assign bus = (data_i & oe_i) | (~last_q & ~oe_i);
   initial begin
      conv_clk_o = 1'b1;
      cap_o = 8'h00;
      fall_o = 1'b0;
   end
   always @(posedge clk_i) begin
      last_q <= bus;
      fall_o <= 1'b0;
      if (fast_i) begin
         // Two system clocks a period, faster than the rated rate
         conv_clk_o <= ~conv_clk_o;
      end else if (go_i) begin
         // Eight clocks a period stays below the top conversion rate
         ph <= (ph + 1) % 8;
         if (ph == 0) begin
            cap_o <= bus;
            conv_clk_o <= 1'b0;
            fall_o <= 1'b1;
         end
         if (ph == 4) conv_clk_o <= 1'b1;
      end
   end
endmodule

//--- verif/test_adc_sample_output_port.sv
/*
 Self-checking bench for the sample output port against a queue model of the pipe.
 Assumes the host model paces conversions and captures late in each period.
*/
module test_adc_sample_output_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic go = 1'b0;
   logic fast = 1'b0;
   logic out_en_n_i = 1'b0;
   logic sleep_request_i = 1'b0;
   logic [7:0] analog_code_i = 8'h00;
   logic conv_clk, sleeping_o, rate_fault_o, fall, s;
   logic [7:0] word, oe, cap, exp_w;
   logic [7:0] pipe [$];
   int fail_count = 0;
   int comparisons = 0;
   int seed = 32'h853D55A2;
   int n;
   always #5 clk_i = ~clk_i;
   asop_top asop_top_inst (.clk_i(clk_i), .rstn_i(rstn_i), .conv_clk_i(conv_clk),
      .analog_code_i(analog_code_i), .out_en_n_i(out_en_n_i),
      .sleep_request_i(sleep_request_i), .sample_word_bits_o(word),
      .sample_word_bits_oe_o(oe), .sleeping_o(sleeping_o), .rate_fault_o(rate_fault_o));
   asop_host_model asop_host_model_inst (.clk_i(clk_i), .go_i(go), .fast_i(fast), .data_i(word),
      .oe_i(oe), .conv_clk_o(conv_clk), .cap_o(cap), .fall_o(fall));
   task check(string name, logic [7:0] seen, logic [7:0] expv);
      comparisons++;
      if (seen !== expv) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, expv, seen);
      end
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence, keyed to each detected fall
   // ----------------------------------------
   initial begin
      repeat (asop_pkg::PIPE_DEPTH) pipe.push_back(8'h00);
      exp_w = 8'h00;
      repeat (12) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      go <= 1'b1;
      for (int i = 0; i < 200; i++) begin
         n = 0;
         // Look between edges so that every output has settled
         do begin
            @(negedge clk_i);
            n++;
         end while (fall !== 1'b1 && n < 20);
         if (n >= 20) begin
            fail_count++;
            stop_test();
         end
         check("oe", oe, {8{~out_en_n_i}});
         check("sleep", {7'h00, sleeping_o}, {7'h00, sleep_request_i});
         check("fault", {7'h00, rate_fault_o}, 8'h00);
         if (!out_en_n_i) check("word", cap, exp_w);
         if (!sleep_request_i) begin
            pipe.push_front(analog_code_i);
            pipe.delete(asop_pkg::PIPE_DEPTH);
         end
         // Sleep is entered rarely so most periods exercise the pipe
         s = ($random(seed) % 5) == 0;
         if (!s) exp_w = pipe[asop_pkg::PIPE_DEPTH-1];
         @(posedge clk_i);
         sleep_request_i <= s;
         out_en_n_i <= ($random(seed) % 4) == 0;
         analog_code_i <= (i % 16 == 0) ? 8'hFF : (i % 16 == 1) ? 8'h00 : 8'($random(seed));
      end
      // A conversion clock of two system clocks must raise the rate fault
      @(posedge clk_i);
      sleep_request_i <= 1'b0;
      fast <= 1'b1;
      repeat (12) @(negedge clk_i);
      check("rate", {7'h00, rate_fault_o}, 8'h01);
      stop_test();
   end
endmodule
